// ==== pkg/pmc_defs.vh ====
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
// Register byte addresses (word aligned except SIZE1 at 4'h1)
`define PMC_ADDR_POWER   4'h0
`define PMC_ADDR_GATING  4'h4
`define PMC_ADDR_MEMMAP  4'h8
`define PMC_ADDR_SIZE0   4'hC
`define PMC_ADDR_SIZE1   4'h1
// Power register fields
`define PMC_PWR_APD      1
`define PMC_PWR_TURBO    3
`define PMC_PWR_ARRCLK   4
`define PMC_PWR_MCCLK    5
`define PMC_PWR_MASK     8'h3A
// Input gating fields
`define PMC_GT_ADDR      0
`define PMC_GT_CS0       2
`define PMC_GT_CS1       3
`define PMC_GT_CS2       4
`define PMC_GT_ALE       5
`define PMC_GT_WRH       6
`define PMC_GT_MASK      8'h7D
// Memory map fields
`define PMC_MM_PSRAM     0
`define PMC_MM_PSEC      1
`define PMC_MM_PPRI      2
`define PMC_MM_DSEC      3
`define PMC_MM_DPRI      4
`define PMC_MM_PERIPH    7
`define PMC_MM_MASK      8'h9F
`define PMC_MM_CFG_MASK  8'h1E
// Size info read mask for the secondary info register
`define PMC_SIZE1_MASK   8'h3F
`endif

// ==== rtl/pmc_regs.v ====
`timescale 1ns/1ps
`include "pmc_defs.vh"

// Operation
// RULE1: Power register zeroed at power-up only
// RULE2: Power bit 1 enables automatic power-down
// RULE3: Power bit 3 set selects low-power mode
// RULE4: Power bit 4 disconnects clock from array
// RULE5: Power bit 5 disconnects clock from macrocells
// RULE6: Gating bit 0 blocks low address bits
// RULE7: Separate mode: address from port F, muxed pins
// RULE8: Gating bits 4..2 block control strobes 2..0
// RULE9: Gating bit 5 blocks address latch enable
// RULE10: Gating bit 6 blocks high-byte write enable
// RULE11: Memory map reset: bits 1-4 configured, 0,7 cleared
// RULE12: Memory map bits 0-4 only in separate mode
// RULE13: Map bit 0 lets program strobe reach SRAM
// RULE14: Map bit 1 lets program strobe reach secondary
// RULE15: Map bit 2 lets program strobe reach primary
// RULE16: Map bits 3,4 let data reads reach memories
// RULE17: Map bit 7 enables port F peripheral mode
// RULE18: Size info low nibble: primary flash size code
// RULE19: Size info high nibble: SRAM size code
// RULE20: Secondary info low nibble: secondary size code
// RULE21: Secondary info bits 5:4 technology, 7:6 unused
// RULE22: Unused bits read zero, writes ignored
// RULE23: Size info registers read-only build constants
module pmc_regs #(
  parameter [7:0] MEMMAP_CFG   = 8'h1E,   // Build-time memory map choice for bits 1-4
  parameter [3:0] PRI_SIZE     = 4'h6,    // Primary flash size code
  parameter [3:0] SRAM_SIZE    = 4'h5,    // SRAM size code
  parameter [3:0] SEC_SIZE     = 4'h3,    // Secondary memory size code
  parameter [1:0] SEC_TYPE     = 2'h0     // Secondary technology code
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       por,
  input  wire [3:0] avs_address,
  input  wire       avs_read,
  input  wire       avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0] avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire       avs_waitrequest,
  input  wire       separate_bus_mode,
  input  wire [7:0] addr_low,
  input  wire [3:0] port_f_low_pins,
  input  wire [3:0] upper_muxed_addr_data_pins,
  input  wire       control_strobe_0,
  input  wire       control_strobe_1,
  input  wire       control_strobe_2,
  input  wire       ale_in,
  input  wire       high_byte_write_enable,
  input  wire       pld_clock_input,
  input  wire       program_space_strobe,
  input  wire       data_read_strobe,
  output reg  [7:0] array_addr,
  output reg        array_cs0,
  output reg        array_cs1,
  output reg        array_cs2,
  output reg        array_ale,
  output reg        array_wrh,
  output reg        array_clk,
  output reg        macrocell_clk,
  output reg        pld_low_power,
  output reg        automatic_power_down,
  output reg        pld_wake,
  output reg        prog_sram_access,
  output reg        prog_secondary_access,
  output reg        prog_primary_access,
  output reg        data_secondary_access,
  output reg        data_primary_access,
  output reg        port_f_peripheral_mode
);

  reg  [7:0] power_mode_control_reg;    // Survives ordinary reset
  reg  [7:0] pld_input_gating_reg;      // Input gating
  reg  [7:0] memory_space_mapping_reg;  // Memory map
  reg        clk_in_last_reg;           // Last clock input level
  reg        rd_pending_reg;            // Read data already staged
  wire [7:0] flash_sram_size_info;      // Constant size codes
  wire [7:0] secondary_memory_info;     // Constant secondary info
  wire       wr_lane0;                  // Write touches the low byte
  wire [7:0] sel_addr;                  // Address seen by array
  wire       map_on;                    // Map bits active
  wire       gate_addr;
  wire       gate_cs0;
  wire       gate_cs1;
  wire       gate_cs2;
  wire       gate_ale;
  wire       gate_wrh;
  reg  [7:0] rd_mux;                    // Selected read value

  // Reads take one wait cycle so data comes from a flop
  assign avs_waitrequest = avs_read & ~rd_pending_reg;
  assign wr_lane0        = avs_write & avs_byteenable[0];

  // Fixed build codes, never writable; see RULE23
  assign flash_sram_size_info  = {SRAM_SIZE, PRI_SIZE}; // see RULE18 see RULE19
  assign secondary_memory_info = {2'b00, SEC_TYPE, SEC_SIZE} & `PMC_SIZE1_MASK; // see RULE20 see RULE21

  // Power register: only power-on clears it, sys_rst leaves it
  always @(posedge clk) begin
    if (por) begin
      power_mode_control_reg <= 8'h00; // see RULE1
    end else if (wr_lane0 && avs_address == `PMC_ADDR_POWER) begin
      power_mode_control_reg <= avs_writedata[7:0] & `PMC_PWR_MASK; // see RULE22
    end
  end

  // Gating and memory map registers
  always @(posedge clk) begin
    if (por || sys_rst) begin
      pld_input_gating_reg     <= 8'h00;
      memory_space_mapping_reg <= MEMMAP_CFG & `PMC_MM_CFG_MASK; // see RULE11
    end else if (wr_lane0) begin
      case (avs_address)
        `PMC_ADDR_GATING: begin
          pld_input_gating_reg <= avs_writedata[7:0] & `PMC_GT_MASK; // see RULE22
        end
        `PMC_ADDR_MEMMAP: begin
          memory_space_mapping_reg <= avs_writedata[7:0] & `PMC_MM_MASK; // see RULE22
        end
        default: begin
          // Size registers ignore writes
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  // Kept combinational so the staging flop is the only register
  // in the read path, which pins the wait at exactly one cycle
  always @* begin
    rd_mux = 8'h00;                                  // Default for holes in the map
    case (avs_address)
      `PMC_ADDR_POWER: begin
        rd_mux = power_mode_control_reg;             // Power controls
      end
      `PMC_ADDR_GATING: begin
        rd_mux = pld_input_gating_reg;               // Input gating
      end
      `PMC_ADDR_MEMMAP: begin
        rd_mux = memory_space_mapping_reg;           // Memory map
      end
      `PMC_ADDR_SIZE0: begin
        rd_mux = flash_sram_size_info;               // see RULE18 see RULE19
      end
      `PMC_ADDR_SIZE1: begin
        rd_mux = secondary_memory_info;              // see RULE20 see RULE21
      end
      default: begin
        rd_mux = 8'h00;                              // Unmapped offsets; see RULE22
      end
    endcase
  end

  // Stage read data, then release waitrequest
  // The pending flag drops on the answering edge whatever the master
  // does next, so a held read starts a fresh two-cycle transfer
  always @(posedge clk) begin
    if (sys_rst) begin
      rd_pending_reg <= 1'b0;                        // No read in flight
      avs_readdata   <= 32'h00000000;                // Quiet bus
    end else if (avs_read && !rd_pending_reg) begin
      rd_pending_reg <= 1'b1;                        // Data staged this edge
      avs_readdata   <= {24'h000000, rd_mux};        // Upper lanes zero; see RULE22
    end else begin
      rd_pending_reg <= 1'b0;                        // Answer given or idle
    end
  end

  // Separate bus mode rebuilds the low address; see RULE7
  // Low nibble from port F, high nibble from the muxed pins
  assign sel_addr  = separate_bus_mode ? {upper_muxed_addr_data_pins, port_f_low_pins} : addr_low;

  // Map bits 0-4 only count in separate bus mode; see RULE12
  assign map_on    = separate_bus_mode;

  // One gate flag per array input, named after what it blocks
  assign gate_addr = pld_input_gating_reg[`PMC_GT_ADDR]; // Low address byte
  assign gate_cs0  = pld_input_gating_reg[`PMC_GT_CS0];  // Strobe 0
  assign gate_cs1  = pld_input_gating_reg[`PMC_GT_CS1];  // Strobe 1
  assign gate_cs2  = pld_input_gating_reg[`PMC_GT_CS2];  // Strobe 2
  assign gate_ale  = pld_input_gating_reg[`PMC_GT_ALE];  // Address latch enable
  assign gate_wrh  = pld_input_gating_reg[`PMC_GT_WRH];  // High byte write

  // Address path to the array
  // Blocked bits are parked low rather than held, so a gated array sees no toggling
  always @(posedge clk) begin
    if (sys_rst) begin
      array_addr <= 8'h00;                           // Quiet after reset
    end else if (gate_addr) begin
      array_addr <= 8'h00;                           // Blocked; see RULE6
    end else begin
      array_addr <= sel_addr;                        // Passed; see RULE6 see RULE7
    end
  end

  // Strobe 0 to the array
  // Gate bit 2 cuts it
  always @(posedge clk) begin
    if (sys_rst) begin
      array_cs0 <= 1'b0;                             // Quiet after reset
    end else if (gate_cs0) begin
      array_cs0 <= 1'b0;                             // Blocked; see RULE8
    end else begin
      array_cs0 <= control_strobe_0;                 // Passed; see RULE8
    end
  end

  // Strobe 1 to the array
  // Gate bit 3 cuts it
  always @(posedge clk) begin
    if (sys_rst) begin
      array_cs1 <= 1'b0;                             // Quiet after reset
    end else if (gate_cs1) begin
      array_cs1 <= 1'b0;                             // Blocked; see RULE8
    end else begin
      array_cs1 <= control_strobe_1;                 // Passed; see RULE8
    end
  end

  // Strobe 2 to the array
  // Gate bit 4 cuts it
  always @(posedge clk) begin
    if (sys_rst) begin
      array_cs2 <= 1'b0;                             // Quiet after reset
    end else if (gate_cs2) begin
      array_cs2 <= 1'b0;                             // Blocked; see RULE8
    end else begin
      array_cs2 <= control_strobe_2;                 // Passed; see RULE8
    end
  end

  // Address latch enable to the array
  // Gate bit 5 cuts it
  always @(posedge clk) begin
    if (sys_rst) begin
      array_ale <= 1'b0;                             // Quiet after reset
    end else if (gate_ale) begin
      array_ale <= 1'b0;                             // Blocked; see RULE9
    end else begin
      array_ale <= ale_in;                           // Passed; see RULE9
    end
  end

  // High byte write enable to the array
  // Gate bit 6 cuts it
  always @(posedge clk) begin
    if (sys_rst) begin
      array_wrh <= 1'b0;                             // Quiet after reset
    end else if (gate_wrh) begin
      array_wrh <= 1'b0;                             // Blocked; see RULE10
    end else begin
      array_wrh <= high_byte_write_enable;           // Passed; see RULE10
    end
  end

  // Clock input to the array
  // Sampled on the system clock, so it only carries slow clock inputs
  always @(posedge clk) begin
    if (sys_rst) begin
      array_clk <= 1'b0;                             // Quiet after reset
    end else if (power_mode_control_reg[`PMC_PWR_ARRCLK]) begin
      array_clk <= 1'b0;                             // Disconnected; see RULE4
    end else begin
      array_clk <= pld_clock_input;                  // Connected; see RULE4
    end
  end

  // Clock input to the macrocells
  // Same sampling limit as the array clock
  always @(posedge clk) begin
    if (sys_rst) begin
      macrocell_clk <= 1'b0;                         // Quiet after reset
    end else if (power_mode_control_reg[`PMC_PWR_MCCLK]) begin
      macrocell_clk <= 1'b0;                         // Disconnected; see RULE5
    end else begin
      macrocell_clk <= pld_clock_input;              // Connected; see RULE5
    end
  end

  // Mode bits copied out to the power logic
  // A flop stage keeps the outputs glitch free while the bus writes
  always @(posedge clk) begin
    if (sys_rst) begin
      pld_low_power        <= 1'b0;                  // Full power after reset
      automatic_power_down <= 1'b0;                  // Power-down off after reset
    end else begin
      pld_low_power        <= power_mode_control_reg[`PMC_PWR_TURBO]; // see RULE3
      automatic_power_down <= power_mode_control_reg[`PMC_PWR_APD];   // see RULE2
    end
  end

  // Clock input history for the wake detector
  // Reset to low; a clock input parked high gives one wake pulse
  // after reset, harmless since waking only powers the array up
  always @(posedge clk) begin
    if (sys_rst) begin
      clk_in_last_reg <= 1'b0;                       // Assume low
    end else begin
      clk_in_last_reg <= pld_clock_input;            // Last level seen
    end
  end

  // Wake pulse on any clock input change
  // Only with turbo off and the array clock still connected
  always @(posedge clk) begin
    if (sys_rst) begin
      pld_wake <= 1'b0;                              // No wake after reset
    end else if (power_mode_control_reg[`PMC_PWR_TURBO] && !power_mode_control_reg[`PMC_PWR_ARRCLK]) begin
      pld_wake <= pld_clock_input ^ clk_in_last_reg; // Edge seen; see RULE4
    end else begin
      pld_wake <= 1'b0;                              // Turbo on or array clock cut
    end
  end

  // Program strobe to the SRAM
  // Map bit 0, separate bus mode only
  always @(posedge clk) begin
    if (sys_rst) begin
      prog_sram_access <= 1'b0;                      // Quiet after reset
    end else if (map_on && program_space_strobe) begin
      prog_sram_access <= memory_space_mapping_reg[`PMC_MM_PSRAM]; // see RULE13
    end else begin
      prog_sram_access <= 1'b0;                      // No strobe or mode off
    end
  end

  // Program strobe to the secondary memory
  // Map bit 1, separate bus mode only
  always @(posedge clk) begin
    if (sys_rst) begin
      prog_secondary_access <= 1'b0;                 // Quiet after reset
    end else if (map_on && program_space_strobe) begin
      prog_secondary_access <= memory_space_mapping_reg[`PMC_MM_PSEC]; // see RULE14
    end else begin
      prog_secondary_access <= 1'b0;                 // No strobe or mode off
    end
  end

  // Program strobe to the primary flash
  // Map bit 2, separate bus mode only
  always @(posedge clk) begin
    if (sys_rst) begin
      prog_primary_access <= 1'b0;                   // Quiet after reset
    end else if (map_on && program_space_strobe) begin
      prog_primary_access <= memory_space_mapping_reg[`PMC_MM_PPRI]; // see RULE15
    end else begin
      prog_primary_access <= 1'b0;                   // No strobe or mode off
    end
  end

  // Data read strobe to the secondary memory
  // Map bit 3, separate bus mode only
  always @(posedge clk) begin
    if (sys_rst) begin
      data_secondary_access <= 1'b0;                 // Quiet after reset
    end else if (map_on && data_read_strobe) begin
      data_secondary_access <= memory_space_mapping_reg[`PMC_MM_DSEC]; // see RULE16
    end else begin
      data_secondary_access <= 1'b0;                 // No strobe or mode off
    end
  end

  // Data read strobe to the primary flash
  // Map bit 4, separate bus mode only
  always @(posedge clk) begin
    if (sys_rst) begin
      data_primary_access <= 1'b0;                   // Quiet after reset
    end else if (map_on && data_read_strobe) begin
      data_primary_access <= memory_space_mapping_reg[`PMC_MM_DPRI]; // see RULE16
    end else begin
      data_primary_access <= 1'b0;                   // No strobe or mode off
    end
  end

  // Port F peripheral mode works in either bus mode
  always @(posedge clk) begin
    if (sys_rst) begin
      port_f_peripheral_mode <= 1'b0;                // Off after reset
    end else begin
      port_f_peripheral_mode <= memory_space_mapping_reg[`PMC_MM_PERIPH]; // see RULE17
    end
  end

endmodule // pmc_regs

// ==== verification/pmc_properties.sv ====
`timescale 1ns/1ps
// Watches the bus answer and the gated paths to the array except strobe 1
module pmc_properties (
  input wire clk, sys_rst, avs_read, avs_waitrequest, separate_bus_mode,
  input wire [31:0] avs_readdata,
  input wire [7:0] addr_low, array_addr,
  input wire [3:0] port_f_low_pins, upper_muxed_addr_data_pins,
  input wire control_strobe_0, control_strobe_2, ale_in, high_byte_write_enable, pld_clock_input,
  input wire program_space_strobe, data_read_strobe, array_cs0, array_cs2, array_ale, array_wrh,
  input wire array_clk, prog_sram_access, data_primary_access, port_f_peripheral_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait");
  rd_upper_a: assert property (avs_readdata[31:8] == 24'h0) else $error("upper read bits");
  addr_path_a: assert property (array_addr == 8'h0 || array_addr == ($past(separate_bus_mode) ?
    {$past(upper_muxed_addr_data_pins), $past(port_f_low_pins)} : $past(addr_low))) else $error("array address");
  cs0_gate_a: assert property (array_cs0 |-> $past(control_strobe_0)) else $error("strobe 0");
  cs2_gate_a: assert property (array_cs2 |-> $past(control_strobe_2)) else $error("strobe 2");
  ale_gate_a: assert property (array_ale |-> $past(ale_in)) else $error("latch enable");
  wrh_gate_a: assert property (array_wrh |-> $past(high_byte_write_enable)) else $error("high write");
  clk_gate_a: assert property (array_clk |-> $past(pld_clock_input)) else $error("array clock");
  prog_sram_a: assert property (prog_sram_access |-> $past(program_space_strobe)) else $error("sram");
  data_pri_a: assert property (data_primary_access |-> $past(data_read_strobe)) else $error("data");
  map_reset_a: assert property ($fell(sys_rst) |-> !port_f_peripheral_mode) else $error("map reset");
endmodule // pmc_properties

// ==== verification/pmc_mcu_model.sv ====
`timescale 1ns/1ps
// Microcontroller side: address, strobes and clock wander every cycle
module pmc_mcu_model (
  input  wire  clk,
  output logic [23:0] pins
);
  // A held value would hide a stuck gate, so every line keeps moving
  initial pins = 24'h5A3C96;
  always @(posedge clk) pins <= pins * 24'h000005 + 24'h3B1F27;
endmodule // pmc_mcu_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`include "pmc_defs.vh"
module tb;
  logic clk = 0, sys_rst = 1, por = 1, avs_read = 0, avs_write = 0, separate_bus_mode = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0, be = 4'hF;
  logic [31:0] avs_writedata = 32'h0, rd;
  int n_fail = 0, n_compared = 0;
  wire [31:0] avs_readdata;
  wire [7:0] array_addr, addr_low;
  wire [3:0] port_f_low_pins, upper_muxed_addr_data_pins;
  wire [23:0] pins;
  wire avs_waitrequest, control_strobe_0, control_strobe_1, control_strobe_2, ale_in, high_byte_write_enable;
  wire pld_clock_input, program_space_strobe, data_read_strobe, array_cs0, array_cs1, array_cs2, array_ale;
  wire array_wrh, array_clk, macrocell_clk, pld_low_power, automatic_power_down, pld_wake, prog_sram_access;
  wire prog_secondary_access, prog_primary_access, data_secondary_access, data_primary_access, port_f_peripheral_mode;
  assign {data_read_strobe, program_space_strobe, pld_clock_input, high_byte_write_enable, ale_in, control_strobe_2,
    control_strobe_1, control_strobe_0, upper_muxed_addr_data_pins, port_f_low_pins, addr_low} = pins;
  pmc_regs dut (.*);
  pmc_mcu_model mcu (.clk(clk), .pins(pins));
  // Clock at 100 ns period
  always #50 clk = ~clk;
  task stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus cycle, called right after a rising edge; judged at rising edges only
  task bus(bit w, logic [3:0] a, logic [7:0] d);
    int k;
    k = 0;
    avs_address <= a; avs_writedata <= {24'h0, d}; avs_byteenable <= be; avs_write <= w; avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++k < 50);
    if (k >= 50) n_fail++;
    rd = avs_readdata;
    avs_read <= 0; avs_write <= 0;
    @(posedge clk);
  endtask
  task rc(logic [3:0] a, logic [7:0] e);
    bus(0, a, 8'h0);
    chk("register", rd, {24'h0, e});
  endtask
  // Outputs follow the pins one cycle later, gated by the register bits
  task io(logic [7:0] p, logic [7:0] g, logic [7:0] m);
    logic [23:0] s, s0;
    logic sp;
    for (int j = 0; j < 8; j++) begin
      @(negedge clk);
      if (j > 0) begin
        chk("array", {array_addr, array_cs2, array_cs1, array_cs0, array_ale, array_wrh, array_clk, macrocell_clk},
          {g[0] ? 8'h0 : (sp ? s[15:8] : s[7:0]), s[18] & !g[4], s[17] & !g[3], s[16] & !g[2], s[19] & !g[5],
          s[20] & !g[6], s[21] & !p[4], s[21] & !p[5]});
        chk("mode", {pld_low_power, automatic_power_down, port_f_peripheral_mode}, {p[3], p[1], m[7]});
        chk("access", {prog_sram_access, prog_secondary_access, prog_primary_access, data_secondary_access,
          data_primary_access}, sp ? {s[22] & m[0], s[22] & m[1], s[22] & m[2], s[23] & m[3], s[23] & m[4]} : 5'h00);
      end
      if (j > 1) chk("wake", pld_wake, (s[21] ^ s0[21]) & p[3] & !p[4]);
      s0 = s; s = pins; sp = separate_bus_mode;
    end
    @(posedge clk);
  endtask
  task t_reset;
    rc(`PMC_ADDR_POWER, 8'h00);
    rc(`PMC_ADDR_GATING, 8'h00);
    rc(`PMC_ADDR_MEMMAP, 8'h1E);
    rc(`PMC_ADDR_SIZE0, 8'h56);
    rc(`PMC_ADDR_SIZE1, 8'h03);
  endtask
  // All ones written everywhere except size 0, which gets zeros; lane 0 masked once
  task t_regs;
    be = 4'h0; bus(1, `PMC_ADDR_POWER, 8'hFF); be = 4'hF;
    rc(`PMC_ADDR_POWER, 8'h00);
    bus(1, `PMC_ADDR_POWER, 8'hFF); bus(1, `PMC_ADDR_GATING, 8'hFF); bus(1, `PMC_ADDR_MEMMAP, 8'hFF);
    bus(1, `PMC_ADDR_SIZE0, 8'h00); bus(1, `PMC_ADDR_SIZE1, 8'hFF);
    rc(`PMC_ADDR_POWER, 8'h3A); rc(`PMC_ADDR_GATING, 8'h7D); rc(`PMC_ADDR_MEMMAP, 8'h9F);
    rc(`PMC_ADDR_SIZE0, 8'h56);
    rc(`PMC_ADDR_SIZE1, 8'h03);
  endtask
  task t_gate;
    logic [7:0] tp [4] = '{8'h00, 8'h3A, 8'h28, 8'h12};
    logic [7:0] tg [4] = '{8'h00, 8'h7D, 8'h54, 8'h29};
    logic [7:0] tm [4] = '{8'h00, 8'h9F, 8'h15, 8'h80};
    for (int i = 0; i < 4; i++) begin
      bus(1, `PMC_ADDR_POWER, tp[i]); bus(1, `PMC_ADDR_GATING, tg[i]); bus(1, `PMC_ADDR_MEMMAP, tm[i]);
      separate_bus_mode <= i[0];
      io(tp[i], tg[i], tm[i]);
    end
  endtask
  // Plain reset keeps the power bits, power-on clears them
  task t_keep;
    bus(1, `PMC_ADDR_POWER, 8'h3A);
    sys_rst <= 1; @(posedge clk); sys_rst <= 0; @(posedge clk);
    rc(`PMC_ADDR_POWER, 8'h3A); rc(`PMC_ADDR_GATING, 8'h00); rc(`PMC_ADDR_MEMMAP, 8'h1E);
    por <= 1; @(posedge clk); por <= 0; @(posedge clk);
    rc(`PMC_ADDR_POWER, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 0; por <= 0;
    @(posedge clk);
    t_reset; t_regs; t_gate; t_keep;
    stop_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule // tb
bind pmc_regs pmc_properties chk_i (.*);
